// *** core/ext_irq_pkg.sv ***
// Purpose: shared constants and types for the external interrupt sensitivity block
// Assumes: 32-bit AXI4-Lite register access, 25 MHz clock
// Notes:   one control register plus pending, status, mask and priority words

package ext_irq_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ext_irq_control_off = 8'h28;
   localparam logic [7:0] pending_off         = 8'h2c;
   localparam logic [7:0] irq_status_off      = 8'h30;
   localparam logic [7:0] irq_mask_off        = 8'h34;
   localparam logic [7:0] core_prio_off       = 8'h38;
   localparam logic [7:0] ctrl_reset          = 8'h00;
   localparam logic [3:0] mask_reset          = 4'h0;

   // ****************************************
   // control field positions
   // ****************************************
   localparam int portb_sense_hi      = 7;
   localparam int portb_sense_lo      = 6;
   localparam int portb_low_inv_pos   = 5;
   localparam int portaef_sense_hi    = 4;
   localparam int portaef_sense_lo    = 3;
   localparam int porta_e_inv_pos     = 2;
   localparam logic [7:0] ctrl_write_mask = 8'hfc;

   localparam int n_sources   = 4;
   localparam int n_pins      = 9;
   localparam logic [1:0] prio_level3 = 2'b11;

   typedef enum logic [1:0] {
      sense_fall_low = 2'b00,
      sense_rise     = 2'b01,
      sense_fall     = 2'b10,
      sense_both     = 2'b11
   } sense_t;

   typedef struct packed {
      logic [1:0] portb_sense_field;
      logic       portb_low_polarity_invert;
      logic [1:0] portaef_sense_field;
      logic       porta_e_polarity_invert;
      logic [1:0] reserved;
   } ctrl_t;

   typedef struct packed {
      logic [3:0] porta_pins;
      logic [1:0] porte_pins;
      logic [2:0] portf_pins;
      logic [4:0] portb_pins;
   } ext_pins_t;

endpackage : ext_irq_pkg

// *** core/ext_irq_detect.sv ***
// Purpose: one source: pin synchroniser, edge and level detect, pending flag
// Assumes: pins asynchronous to clk
// Notes:   the edge plus level mode keeps the request up while the level lasts

`timescale 1ns/1ps

module ext_irq_detect #(
   parameter int width = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [width-1:0] pins,
   input  wire logic [1:0]       code,
   input  wire logic             invert,
   input  wire logic             clear,
   input  wire logic             ack,
   output logic                  pending,
   output logic                  event_pulse
);
   import ext_irq_pkg::*;

   logic [width-1:0] sync1_ff;
   logic [width-1:0] sync2_ff;
   logic [width-1:0] prev_ff;
   logic [width-1:0] rise;
   logic [width-1:0] fall;
   logic             any_rise;
   logic             any_fall;
   logic             level_hit;
   logic             hit;
   logic             pending_ff;

   // ****************************************
   // synchroniser and history
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_ff <= '1;
         sync2_ff <= '1;
         prev_ff  <= '1;
      end else begin
         sync1_ff <= pins;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   // ****************************************
   // event decode
   // ****************************************
   always_comb begin
      rise      = sync2_ff & ~prev_ff;
      fall      = ~sync2_ff & prev_ff;
      any_rise  = |rise;
      any_fall  = |fall;
      // invert swaps rise and fall, low level becomes high level
      level_hit = invert ? (|sync2_ff) : ~(&sync2_ff);
      case (sense_t'(code))
         sense_fall_low: hit = (invert ? any_rise : any_fall) | level_hit;
         sense_rise:     hit = invert ? any_fall : any_rise;
         sense_fall:     hit = invert ? any_rise : any_fall;
         sense_both:     hit = any_rise | any_fall;
         default:        hit = 1'b0;
      endcase
   end

   // ****************************************
   // pending flag, event wins over ack
   // ****************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pending_ff <= 1'b0;
      end else if (clear) begin
         pending_ff <= 1'b0;
      end else if (hit) begin
         pending_ff <= 1'b1;
      end else if (ack) begin
         pending_ff <= 1'b0;
      end
   end

   assign pending     = pending_ff;
   assign event_pulse = hit & ~clear;

endmodule : ext_irq_detect

// *** core/ext_irq_sensitivity_ctrl.sv ***
// Purpose: external interrupt sensitivity control with AXI4-Lite registers
// Assumes: 25 MHz clk, rst_b asynchronous active low, pins asynchronous
// Notes:   pending requests per source go to the cpu interrupt controller
//
// Contract
// - four sources sharing two sensitivity settings
// - falling, rising, both, or edge plus level
// - changed field value clears pending requests
// - bits 7:6 sense for port b sources
// - port b low decode, inverted set too
// - port b pin4 decode without inversion
// - bit 5 inverts port b low source
// - bits 4:3 sense for a/e and f
// - a/e source decodes like port b low
// - port f decode without inversion
// - bit 2 inverts port a/e source
// - a/e source from pa3 and pe1
// - control resets zero at address 0x28
// - level three means both priority bits set
//
// Register access over AXI4-Lite is this design's own decision.

`timescale 1ns/1ps

module ext_irq_sensitivity_ctrl (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic [31:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [31:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire ext_irq_pkg::ext_pins_t ext_pins,
   input  wire logic                   prio_bit_high,
   input  wire logic                   prio_bit_low,
   input  wire logic [3:0]             irq_ack,
   output logic [3:0]                  irq_req,
   output logic                        irq
);
   import ext_irq_pkg::*;

   ctrl_t      ctrl_ff;
   logic [3:0] status_ff;
   logic [3:0] mask_ff;
   logic [31:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0]  wstrb_ff;
   logic        aw_full_ff;
   logic        w_full_ff;
   logic        bvalid_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  bresp_ff;
   logic [1:0]  rresp_ff;
   logic        do_write;
   logic        level3;
   logic [7:0]  nxt_ctrl;
   logic        ctrl_change;
   logic [3:0]  events;
   logic [3:0]  pend;
   logic [7:0]  wr_off;
   logic [7:0]  rd_off;
   logic        wr_ok;
   logic        rd_ok;
   logic        wr_ctrl;
   logic        wr_status;
   logic        wr_mask;
   logic [3:0]  nxt_status;
   logic [3:0]  nxt_mask;
   logic [31:0] nxt_rdata;
   logic [1:0]  nxt_rresp;

   // ****************************************
   // write channel capture
   // ****************************************
   // each half of a write parks in its own holder until both are there
   assign s_axi_awready = !aw_full_ff;
   assign s_axi_wready  = !w_full_ff;
   assign do_write      = aw_full_ff && w_full_ff && !bvalid_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_full_ff <= 1'b0;
         awaddr_ff  <= 32'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_ff <= 1'b1;
         awaddr_ff  <= s_axi_awaddr;
      end else if (do_write) begin
         aw_full_ff <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         w_full_ff <= 1'b0;
         wdata_ff  <= 32'h0;
         wstrb_ff  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_ff <= 1'b1;
         wdata_ff  <= s_axi_wdata;
         wstrb_ff  <= s_axi_wstrb;
      end else if (do_write) begin
         w_full_ff <= 1'b0;
      end
   end

   // ****************************************
   // write decode
   // ****************************************
   assign wr_off = awaddr_ff[7:0];
   assign wr_ok  = (awaddr_ff[31:8] == 24'h0) &&
                   (wr_off == ext_irq_control_off || wr_off == pending_off ||
                    wr_off == irq_status_off || wr_off == irq_mask_off ||
                    wr_off == core_prio_off);
   assign level3 = ({prio_bit_high, prio_bit_low} == prio_level3);
   // a refused address leaves every register untouched
   assign wr_ctrl   = do_write && wr_ok && wr_off == ext_irq_control_off && wstrb_ff[0];
   assign wr_status = do_write && wr_ok && wr_off == irq_status_off && wstrb_ff[0];
   assign wr_mask   = do_write && wr_ok && wr_off == irq_mask_off && wstrb_ff[0];

   always_comb begin
      nxt_ctrl = ctrl_ff;
      // reserved bits stay zero whatever software writes
      if (wr_ctrl) begin
         nxt_ctrl = wdata_ff[7:0] & ctrl_write_mask;
      end
   end
   assign ctrl_change = (nxt_ctrl != ctrl_ff);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= ctrl_t'(ctrl_reset);
      end else begin
         // level three guard is software's duty; write accepted regardless
         ctrl_ff <= nxt_ctrl;
      end
   end

   // answer waits until both halves of the write are held
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bvalid_ff <= 1'b0;
         bresp_ff  <= 2'b00;
      end else if (do_write) begin
         bvalid_ff <= 1'b1;
         bresp_ff  <= wr_ok ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // ****************************************
   // sources
   // ****************************************
   // one shared clear: any changed field drops all four requests
   // a/e source: pa3 and pe1 combined
   ext_irq_detect #(.width(2)) u_src_a_e (
      .clk         (clk),
      .rst_b       (rst_b),
      .pins        ({ext_pins.porta_pins[3], ext_pins.porte_pins[1]}),
      .code        (ctrl_ff.portaef_sense_field),
      .invert      (ctrl_ff.porta_e_polarity_invert),
      .clear       (ctrl_change),
      .ack         (irq_ack[0]),
      .pending     (pend[0]),
      .event_pulse (events[0])
   );

   ext_irq_detect #(.width(3)) u_src_f (
      .clk         (clk),
      .rst_b       (rst_b),
      .pins        (ext_pins.portf_pins),
      .code        (ctrl_ff.portaef_sense_field),
      .invert      (1'b0),
      .clear       (ctrl_change),
      .ack         (irq_ack[1]),
      .pending     (pend[1]),
      .event_pulse (events[1])
   );

   ext_irq_detect #(.width(4)) u_src_b_low (
      .clk         (clk),
      .rst_b       (rst_b),
      .pins        (ext_pins.portb_pins[3:0]),
      .code        (ctrl_ff.portb_sense_field),
      .invert      (ctrl_ff.portb_low_polarity_invert),
      .clear       (ctrl_change),
      .ack         (irq_ack[2]),
      .pending     (pend[2]),
      .event_pulse (events[2])
   );

   ext_irq_detect #(.width(1)) u_src_b_pin4 (
      .clk         (clk),
      .rst_b       (rst_b),
      .pins        (ext_pins.portb_pins[4]),
      .code        (ctrl_ff.portb_sense_field),
      .invert      (1'b0),
      .clear       (ctrl_change),
      .ack         (irq_ack[3]),
      .pending     (pend[3]),
      .event_pulse (events[3])
   );

   assign irq_req = pend;

   // ****************************************
   // sticky status, mask, interrupt
   // ****************************************
   always_comb begin
      nxt_status = status_ff | events;
      // a new event outranks the clearing write in the same cycle
      if (wr_status) begin
         nxt_status = (status_ff & ~wdata_ff[3:0]) | events;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_ff <= 4'h0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_comb begin
      // mask gates the interrupt line only, never the status
      nxt_mask = mask_ff;
      if (wr_mask) begin
         nxt_mask = wdata_ff[3:0];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_ff <= mask_reset;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // level output straight from the status and mask flops
   assign irq = |(status_ff & mask_ff);

   // ****************************************
   // read channel
   // ****************************************
   // reads decode the live address, so no address holder
   // data latched when the address is taken, steady while rvalid waits
   assign s_axi_arready = !rvalid_ff;
   assign rd_off        = s_axi_araddr[7:0];
   assign rd_ok         = (s_axi_araddr[31:8] == 24'h0);

   always_comb begin
      nxt_rdata = 32'h0;
      nxt_rresp = 2'b00;
      if (!rd_ok) begin
         nxt_rresp = 2'b10;
      end else begin
         case (rd_off)
            ext_irq_control_off: nxt_rdata = {24'h0, ctrl_ff};
            pending_off:         nxt_rdata = {28'h0, pend};
            irq_status_off:      nxt_rdata = {28'h0, status_ff};
            irq_mask_off:        nxt_rdata = {28'h0, mask_ff};
            core_prio_off:       nxt_rdata = {31'h0, level3};
            default:             nxt_rresp = 2'b10;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 32'h0;
         rresp_ff  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_ff <= 1'b1;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

endmodule : ext_irq_sensitivity_ctrl

// *** testbench/ext_irq_checker.sv ***
// Purpose: port assertions for the sensitivity block
// Assumes: one clock, rst_b async active low
// Notes:   shadows follow control and mask writes
`timescale 1ns/1ps
module ext_irq_checker (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [31:0] s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        prio_bit_high,
   input wire logic        prio_bit_low,
   input wire logic [3:0]  irq_req,
   input wire logic        irq
);
   import ext_irq_pkg::*;
   // ****
   // shadows and checks
   // ****
   logic [31:0] wa_ff;
   logic [31:0] wd_ff;
   logic [7:0]  ctrl_ff;
   logic [3:0]  mask_ff;
   wire         both_prio = prio_bit_high & prio_bit_low;
   wire         rd_take   = s_axi_arvalid && s_axi_arready;
   wire         ctrl_chg  = wa_ff == 32'h28 && (wd_ff[7:0] & ctrl_write_mask) != ctrl_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wa_ff <= 32'h0;
         wd_ff <= 32'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) wa_ff <= s_axi_awaddr;
         if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_ff <= ctrl_reset;
         mask_ff <= mask_reset;
      end else if ($rose(s_axi_bvalid) && s_axi_bresp == 2'b00) begin
         if (wa_ff == 32'h28) ctrl_ff <= wd_ff[7:0] & ctrl_write_mask;
         if (wa_ff == 32'h34) mask_ff <= wd_ff[3:0];
      end
   end
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer late");
   a_resp_single: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer twice");
   a_unmapped_err: assert property (rd_take && !(s_axi_araddr inside {32'h28, 32'h2c, 32'h30, 32'h34, 32'h38})
      |=> s_axi_rresp == 2'b10) else $error("unmapped read accepted");
   a_ctrl_readback: assert property (rd_take && s_axi_araddr == 32'h28 |=> s_axi_rdata == {24'h0, ctrl_ff})
      else $error("control readback wrong");
   a_prio_readback: assert property (rd_take && s_axi_araddr == 32'h38 |=> s_axi_rdata[0] == $past(both_prio))
      else $error("priority readback wrong");
   a_ctrl_clears: assert property ($rose(s_axi_bvalid) && ctrl_chg |-> irq_req == 4'h0)
      else $error("pending kept after control change");
   a_irq_masked: assert property (mask_ff == 4'h0 && !$rose(s_axi_bvalid) |-> !irq)
      else $error("irq while masked");
endmodule : ext_irq_checker

// *** testbench/ext_side_model.sv ***
// Purpose: pins and cpu side facing the sensitivity block
// Assumes: pins idle high through pull-ups
// Notes:   one ack pulse acks all four sources at once
`timescale 1ns/1ps
module ext_side_model (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire ext_irq_pkg::ext_pins_t pin_goal,
   input  wire logic                   ack_all,
   input  wire logic                   lvl3,
   output ext_irq_pkg::ext_pins_t      ext_pins,
   output logic [3:0]                  irq_ack,
   output logic                        prio_bit_high,
   output logic                        prio_bit_low
);
   import ext_irq_pkg::*;
   // ****
   // pin drive and cpu priority
   // ****
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_pins <= 14'h3fff;
         irq_ack  <= 4'h0;
      end else begin
         ext_pins <= pin_goal;
         irq_ack  <= {4{ack_all}};
      end
   end
   assign prio_bit_high = 1'b1;
   assign prio_bit_low  = lvl3;
endmodule : ext_side_model

// *** testbench/tb_top.sv ***
// Purpose: register and pin tests of the sensitivity block
// Assumes: 25 MHz clk, pins from ext_side_model
// Notes:   expected requests worked out in exp_req
`timescale 1ns/1ps
module tb_top;
   import ext_irq_pkg::*;
   // ****
   // stimulus and tests
   // ****
   logic        clk = 1'b0, rst_b = 1'b0, ack_all = 1'b0, lvl3 = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, q;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   wire         awready, wready, bvalid, arready, rvalid, irq, p_hi, p_lo;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [3:0]   ack, irq_req;
   ext_pins_t   pin_goal = 14'h3fff;
   ext_pins_t   pins;
   ext_pins_t   tr [8] = '{14'h3fff, 14'h0000, 14'h0000, 14'h3fff, 14'h3fff, 14'h3def, 14'h3fff, 14'h1ffe};
   logic [1:0]  rs;
   logic [7:0]  c;
   int          n_fail = 0, num_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   ext_irq_sensitivity_ctrl uut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_pins(pins),
      .prio_bit_high(p_hi), .prio_bit_low(p_lo), .irq_ack(ack), .irq_req(irq_req), .irq(irq));
   ext_side_model far (.clk(clk), .rst_b(rst_b), .pin_goal(pin_goal), .ack_all(ack_all), .lvl3(lvl3),
      .ext_pins(pins), .irq_ack(ack), .prio_bit_high(p_hi), .prio_bit_low(p_lo));
   function automatic logic [3:0] exp_req(logic [7:0] c, ext_pins_t o, ext_pins_t n);
      logic [9:0] go, gn, gm;
      logic [3:0] e;
      logic       inv, f, r, lv;
      go = {o.portb_pins, o.portf_pins, o.porta_pins[3], o.porte_pins[1]};
      gn = {n.portb_pins, n.portf_pins, n.porta_pins[3], n.porte_pins[1]};
      for (int i = 0; i < 4; i++) begin
         gm = i == 0 ? 10'h003 : i == 1 ? 10'h01c : i == 2 ? 10'h1e0 : 10'h200;
         f = |(go & ~gn & gm);
         r = |(~go & gn & gm);
         inv = i == 0 ? c[2] : i == 2 ? c[5] : 1'b0;
         lv = inv ? |((go | gn) & gm) : |(~(go & gn) & gm);
         case (i < 2 ? c[4:3] : c[7:6])
            2'b00: e[i] = lv;
            2'b01: e[i] = inv ? f : r;
            2'b10: e[i] = inv ? r : f;
            default: e[i] = f | r;
         endcase
      end
      return e;
   endfunction : exp_req
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      logic pa, pw, ta, tw;
      @(posedge clk);
      pa = 1'b1;
      pw = wr;
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      arvalid <= !wr;
      bready <= wr;
      rready <= !wr;
      while (pa || pw) begin
         @(negedge clk);
         ta = pa && (wr ? awready : arready);
         tw = pw && wready;
         @(posedge clk);
         if (ta) begin
            pa = 1'b0;
            awvalid <= 1'b0;
            arvalid <= 1'b0;
         end
         if (tw) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      do @(negedge clk); while (!(wr ? bvalid : rvalid));
      q = rdata;
      rs = wr ? bresp : rresp;
      @(posedge clk);
      bready <= 1'b0;
      rready <= 1'b0;
   endtask : xfer
   task automatic rdchk(input string nm, input logic [31:0] a, input logic [31:0] ex);
      xfer(1'b0, a, 32'h0);
      chk(nm, ex, q);
   endtask : rdchk
   task automatic step(input ext_pins_t o, input ext_pins_t n);
      @(posedge clk);
      pin_goal <= o;
      repeat (8) @(posedge clk);
      ack_all <= 1'b1;
      @(posedge clk);
      ack_all <= 1'b0;
      repeat (2) @(posedge clk);
      pin_goal <= n;
      repeat (8) @(posedge clk);
      @(negedge clk);
   endtask : step
   task automatic report_and_stop;
      if (n_fail == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : report_and_stop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         n_fail++;
         report_and_stop();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      rdchk("ctrl", 32'h28, 32'h0);
      rdchk("mask", 32'h34, 32'h0);
      lvl3 <= 1'b0;
      repeat (4) @(posedge clk);
      rdchk("level3", 32'h38, 32'h0);
      lvl3 <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk("level3", 32'h38, 32'h1);
      for (int k = 0; k < 8; k++) begin
         c = {k[1:0], k[2], k[1:0], k[2], 2'b00};
         xfer(1'b1, 32'h28, {24'h0, c});
         rdchk("ctrl", 32'h28, {24'h0, c});
         for (int t = 0; t < 8; t += 2) begin
            step(tr[t], tr[t + 1]);
            chk("irq_req", {28'h0, exp_req(c, tr[t], tr[t + 1])}, {28'h0, irq_req});
         end
      end
      xfer(1'b1, 32'h28, 32'h90);
      step(14'h3fff, 14'h0000);
      chk("irq", 32'h0, {31'h0, irq});
      rdchk("pending", 32'h2c, 32'hf);
      rdchk("status", 32'h30, 32'hf);
      xfer(1'b1, 32'h34, 32'hf);
      @(negedge clk);
      chk("irq", 32'h1, {31'h0, irq});
      xfer(1'b1, 32'h28, 32'h90);
      rdchk("pending", 32'h2c, 32'hf);
      xfer(1'b1, 32'h28, 32'h50);
      rdchk("pending", 32'h2c, 32'h0);
      xfer(1'b1, 32'h30, 32'hf);
      rdchk("status", 32'h30, 32'h0);
      @(negedge clk);
      chk("irq", 32'h0, {31'h0, irq});
      xfer(1'b0, 32'h3c, 32'h0);
      chk("rresp", 32'h2, {30'h0, rs});
      xfer(1'b1, 32'h40, 32'h0);
      chk("bresp", 32'h2, {30'h0, rs});
      report_and_stop();
   end
endmodule : tb_top
bind ext_irq_sensitivity_ctrl ext_irq_checker chk_i (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .prio_bit_high(prio_bit_high),
   .prio_bit_low(prio_bit_low), .irq_req(irq_req), .irq(irq));
